// ---- verilog/tw_pkg.sv ----
// Shared constants and types of the two-wire memory port.
package tw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Addressing
  localparam logic [7:0] MAIN_DEV_DEFAULT = 8'hA2; // Main block default
  localparam logic [7:0] SEC_DEV_ADDR = 8'hA0; // Secondary block, fixed
  localparam logic [7:0] VCC_FLAG_ADDR = 8'h70; // Byte holding alarm flag
  localparam int unsigned VCC_FLAG_BIT = 4; // Alarm flag position
  localparam int unsigned MEM_BYTES = 256; // Bytes per block
  localparam int unsigned PAGE_BYTES = 8; // Page write size
  localparam int unsigned PAGE_W = 3; // Offset bits inside a page
  localparam logic [3:0] BYTE_BITS = 4'h8; // Data bits per byte
  localparam logic [1:0] LAST_PHASE = 2'h3; // Last quarter of a bit

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_MHZ = 125; // System clock rate
  localparam int unsigned WRITE_CYCLE_US = 5000; // Self-timed write
  localparam int unsigned TW_CYCLES = WRITE_CYCLE_US * CLK_MHZ;
  localparam int unsigned TWC_W = 24; // Write timer width
  localparam int unsigned SCL_KHZ = 100; // Serial clock rate of the host
  localparam int unsigned SCL_QTR_CYCLES = (CLK_MHZ * 1000) / (4 * SCL_KHZ);
  localparam int unsigned DIV_W = 16; // Divider width

  ////////////////////////////////////////////////////////////////////////////
  // Host commands
  typedef enum logic [1:0] {
    TW_OP_START,
    TW_OP_STOP,
    TW_OP_WRITE,
    TW_OP_READ
  } tw_op_t;

endpackage

// ---- verilog/tw_if.sv ----
// Open-drain two-wire bus joining the host end and the memory end.
interface tw_if;
  logic scl_m_o; // Host clock drive value
  logic scl_m_oe_n; // Host clock enable, low drives
  logic sda_m_o; // Host data drive value
  logic sda_m_oe_n; // Host data enable, low drives
  logic sda_s_o; // Memory data drive value
  logic sda_s_oe_n; // Memory data enable, low drives
  logic scl; // Resolved clock line
  logic sda; // Resolved data line

  // Wired-AND with pull-ups
  assign scl = scl_m_oe_n ? 1'b1 : scl_m_o;
  assign sda = (sda_m_oe_n ? 1'b1 : sda_m_o) & (sda_s_oe_n ? 1'b1 : sda_s_o);

  modport dev (input scl, input sda, output sda_s_o, output sda_s_oe_n);
  modport host (input scl, input sda, output scl_m_o, output scl_m_oe_n,
                output sda_m_o, output sda_m_oe_n);
endinterface

// ---- verilog/tw_sync.sv ----
// Two-flop synchroniser for pins entering the system clock domain.
module tw_sync #(
  parameter int unsigned W = 1,
  parameter logic RST = 1'b1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q; // First stage, read only by second stage
  logic [W-1:0] sync_q; // Second stage

  // Lines idle high, so reset to the idle level
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_q <= {W{RST}};
      sync_q <= {W{RST}};
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule // tw_sync

// ---- verilog/tw_slave.sv ----
// Memory end of the two-wire port: slave protocol, page buffer, storage.
module tw_slave #(
  parameter int unsigned TW_CYC = tw_pkg::TW_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  tw_if.dev bus,
  input wire logic [7:0] main_addr_prog, // Programmed main block address
  input wire logic addr_recalled, // Nonvolatile settings are recalled
  input wire logic write_protect, // Refuse write accesses
  input wire logic vcc_conv_done, // Supply conversion finished, pulse
  input wire logic vcc_low_meas, // Result of that conversion
  output logic vcc_low_flag, // Supply-low alarm flag
  output logic write_busy, // Self-timed write in progress
  output logic standby // Low-power state
);
  import tw_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_ACK_DEV,
    S_RX,
    S_ACK_RX,
    S_TX,
    S_ACK_TX
  } tw_sl_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and bus events
  logic [1:0] pins_s; // Synchronised clock and data
  logic scl_s; // Clock line, synchronised
  logic sda_s; // Data line, synchronised
  logic scl_p_q; // Clock one cycle earlier
  logic sda_p_q; // Data one cycle earlier
  logic scl_r; // Clock rising
  logic scl_f; // Clock falling
  logic start; // Start condition
  logic stop; // Stop condition

  tw_sync #(
    .W(2),
    .RST(1'b1)
  ) u_sync (
    .clock(clock),
    .resetn(resetn),
    .din({bus.scl, bus.sda}),
    .dout(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Previous samples for edge finding
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Both lines pass the same synchroniser, so their skew is preserved
  assign scl_r = scl_s & ~scl_p_q;
  assign scl_f = ~scl_s & scl_p_q;
  assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop = scl_s & scl_p_q & ~sda_p_q & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0] main_mem [MEM_BYTES]; // Main block
  logic [7:0] sec_mem [MEM_BYTES]; // Secondary block
  logic [7:0] rd_byte; // Byte at the pointer as seen by the master
  logic [7:0] main_dev; // Active main block address
  logic hit_main; // Address byte selects main block
  logic hit_sec; // Address byte selects secondary block

  ////////////////////////////////////////////////////////////////////////////
  // State
  tw_sl_state_t state_q, state_d; // Protocol state
  logic [3:0] cnt_q, cnt_d; // Bits moved in this byte
  logic [7:0] sh_q, sh_d; // Shift register
  logic drv_q, drv_d; // Pull data line low
  logic blk_q, blk_d; // Selected block, one is main
  logic rw_q, rw_d; // Direction of the access
  logic first_q, first_d; // Next received byte is the memory address
  logic [7:0] ptr_q, ptr_d; // Address pointer
  logic mack_q, mack_d; // Master acknowledged the last byte
  logic [PAGE_BYTES-1:0] mask_q, mask_d; // Filled page slots
  logic [PAGE_BYTES-1:0][7:0] pbuf_q, pbuf_d; // Page buffer
  logic [7-PAGE_W:0] page_q, page_d; // Page being written
  logic wblk_q, wblk_d; // Block being written
  logic busy_q, busy_d; // Timed write running
  logic [TWC_W-1:0] twc_q, twc_d; // Write cycle countdown
  logic vlow_q, vlow_d; // Supply-low alarm flag
  logic commit; // Move page buffer into storage

  // Main address falls back to the default until settings are recalled
  assign main_dev = addr_recalled ? main_addr_prog : MAIN_DEV_DEFAULT;
  assign hit_main = sh_q[7:1] == main_dev[7:1];
  assign hit_sec = sh_q[7:1] == SEC_DEV_ADDR[7:1];

  // Read data, with the live alarm flag folded into its byte
  always_comb begin
    rd_byte = blk_q ? main_mem[ptr_q] : sec_mem[ptr_q];
    if (blk_q && ptr_q == VCC_FLAG_ADDR) begin
      rd_byte[VCC_FLAG_BIT] = vlow_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    drv_d = drv_q;
    blk_d = blk_q;
    rw_d = rw_q;
    first_d = first_q;
    ptr_d = ptr_q;
    mack_d = mack_q;
    mask_d = mask_q;
    pbuf_d = pbuf_q;
    page_d = page_q;
    wblk_d = wblk_q;
    busy_d = busy_q;
    twc_d = twc_q;
    vlow_d = vlow_q;
    commit = 1'b0;
    // Write timer; its end returns the block to standby if the protocol state is idle
    if (busy_q) begin
      if (twc_q == TWC_W'(1)) begin
        busy_d = 1'b0;
      end
      twc_d = twc_q - TWC_W'(1);
    end
    // Conversion result replaces the power-up value
    if (vcc_conv_done) begin
      vlow_d = vcc_low_meas;
    end
    if (start) begin
      // Repeated start drops uncommitted page data
      state_d = S_ADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
      mask_d = '0;
    end else if (stop) begin
      state_d = S_IDLE;
      drv_d = 1'b0;
      // Only a stop commits buffered bytes
      if (mask_q != '0 && !busy_q) begin
        commit = 1'b1;
        busy_d = 1'b1;
        twc_d = TWC_W'(TW_CYC);
        mask_d = '0;
      end
    end else begin
      case (state_q)
        S_ADDR: begin
          if (scl_r) begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_f && cnt_q == BYTE_BITS) begin
            // Busy, unmatched or protected writes get no acknowledge
            if ((hit_main || hit_sec) && !busy_q
                && (sh_q[0] || !write_protect)) begin
              drv_d = 1'b1;
              blk_d = hit_main;
              rw_d = sh_q[0];
              state_d = S_ACK_DEV;
            end else begin
              state_d = S_IDLE;
            end
          end
        end
        S_ACK_DEV: begin
          if (scl_f) begin
            cnt_d = 4'h0;
            if (rw_q) begin
              // Current-address read starts at the pointer
              sh_d = rd_byte;
              drv_d = ~rd_byte[7];
              ptr_d = ptr_q + 8'h01;
              state_d = S_TX;
            end else begin
              drv_d = 1'b0;
              first_d = 1'b1;
              state_d = S_RX;
            end
          end
        end
        S_RX: begin
          if (scl_r) begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_f && cnt_q == BYTE_BITS) begin
            drv_d = 1'b1;
            state_d = S_ACK_RX;
            if (first_q) begin
              ptr_d = sh_q;
            end else begin
              // Ninth byte onward overwrites the earliest slots
              pbuf_d[ptr_q[PAGE_W-1:0]] = sh_q;
              mask_d[ptr_q[PAGE_W-1:0]] = 1'b1;
              page_d = ptr_q[7:PAGE_W];
              wblk_d = blk_q;
              ptr_d = {ptr_q[7:PAGE_W],
                       ptr_q[PAGE_W-1:0] + PAGE_W'(1)};
            end
          end
        end
        S_ACK_RX: begin
          if (scl_f) begin
            drv_d = 1'b0;
            cnt_d = 4'h0;
            first_d = 1'b0;
            state_d = S_RX;
          end
        end
        S_TX: begin
          if (scl_r) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_f) begin
            if (cnt_q == BYTE_BITS) begin
              drv_d = 1'b0; // Leave line to the master's acknowledge
              state_d = S_ACK_TX;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              drv_d = ~sh_q[6];
            end
          end
        end
        S_ACK_TX: begin
          if (scl_r) begin
            mack_d = ~sda_s;
          end else if (scl_f) begin
            if (mack_q) begin
              // Pointer wraps naturally from the last byte to the first
              sh_d = rd_byte;
              drv_d = ~rd_byte[7];
              ptr_d = ptr_q + 8'h01;
              cnt_d = 4'h0;
              state_d = S_TX;
            end else begin
              state_d = S_IDLE;
            end
          end
        end
        default: begin
          state_d = S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      drv_q <= 1'b0;
      blk_q <= 1'b0;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      ptr_q <= 8'h00;
      mack_q <= 1'b0;
      mask_q <= '0;
      pbuf_q <= '0;
      page_q <= '0;
      wblk_q <= 1'b0;
      busy_q <= 1'b0;
      twc_q <= '0;
      vlow_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      drv_q <= drv_d;
      blk_q <= blk_d;
      rw_q <= rw_d;
      first_q <= first_d;
      ptr_q <= ptr_d;
      mack_q <= mack_d;
      mask_q <= mask_d;
      pbuf_q <= pbuf_d;
      page_q <= page_d;
      wblk_q <= wblk_d;
      busy_q <= busy_d;
      twc_q <= twc_d;
      vlow_q <= vlow_d;
    end
  end

  // Storage is written at the stop; the timer then only gates access
  always_ff @(posedge clock) begin
    if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (mask_q[i]) begin
          if (wblk_q) begin
            main_mem[{page_q, PAGE_W'(i)}] <= pbuf_q[i];
          end else begin
            sec_mem[{page_q, PAGE_W'(i)}] <= pbuf_q[i];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; the clock line is never driven by this end
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe_n = ~drv_q;
  assign vcc_low_flag = vlow_q;
  assign write_busy = busy_q;
  assign standby = (state_q == S_IDLE) && !busy_q;
endmodule // tw_slave

// ---- verilog/tw_master.sv ----
// Host end of the two-wire port: byte-level bus master with clock divider.
module tw_master #(
  parameter int unsigned QTR_CYC = tw_pkg::SCL_QTR_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  tw_if.host bus,
  input wire logic cmd_valid, // Command offered
  output logic cmd_ready, // Command accepted when high with valid
  input wire tw_pkg::tw_op_t cmd_op, // Start, stop, write or read
  input wire logic [7:0] cmd_data, // Byte to write
  input wire logic cmd_ack, // Acknowledge to give after a read
  output logic rsp_valid, // Byte finished, one-cycle pulse
  output logic [7:0] rsp_data, // Byte read back
  output logic rsp_ack // Acknowledge seen in the ninth bit
);
  import tw_pkg::*;

  typedef enum logic [1:0] {M_IDLE, M_START, M_STOP, M_BIT} tw_ms_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Data line sampling
  logic sda_s; // Synchronised data line

  tw_sync #(
    .W(1),
    .RST(1'b1)
  ) u_sync (
    .clock(clock),
    .resetn(resetn),
    .din(bus.sda),
    .dout(sda_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  tw_ms_state_t state_q, state_d; // Sequence being run
  logic [DIV_W-1:0] div_q, div_d; // Quarter-bit divider
  logic [1:0] ph_q, ph_d; // Quarter within a bit or condition
  logic [3:0] bit_q, bit_d; // Bit within the nine-bit frame
  logic [8:0] tx_q, tx_d; // Bits to send, one releases the line
  logic [8:0] rx_q, rx_d; // Bits sampled
  logic scl_low_q, scl_low_d; // Pull clock low
  logic sda_rel_q, sda_rel_d; // Release data line
  logic rv_q, rv_d; // Response pulse
  logic [7:0] rd_q, rd_d; // Response byte
  logic ra_q, ra_d; // Response acknowledge
  logic tick; // End of a quarter

  assign tick = div_q == DIV_W'(QTR_CYC - 1);
  assign cmd_ready = state_q == M_IDLE;

  // Sequencer: the end of each quarter sets clock and data from the phase that ends
  always_comb begin
    state_d = state_q;
    div_d = div_q;
    ph_d = ph_q;
    bit_d = bit_q;
    tx_d = tx_q;
    rx_d = rx_q;
    scl_low_d = scl_low_q;
    sda_rel_d = sda_rel_q;
    rv_d = 1'b0;
    rd_d = rd_q;
    ra_d = ra_q;
    if (state_q == M_IDLE) begin
      div_d = '0;
      ph_d = 2'h0;
      if (cmd_valid) begin
        bit_d = 4'h0;
        scl_low_d = 1'b1;
        case (cmd_op)
          TW_OP_START: begin
            state_d = M_START;
            sda_rel_d = 1'b1;
          end
          TW_OP_STOP: begin
            state_d = M_STOP;
            sda_rel_d = 1'b0;
          end
          TW_OP_WRITE: begin
            state_d = M_BIT;
            tx_d = {cmd_data, 1'b1};
            sda_rel_d = cmd_data[7];
          end
          default: begin
            state_d = M_BIT;
            tx_d = {8'hFF, ~cmd_ack};
            sda_rel_d = 1'b1;
          end
        endcase
      end
    end else if (tick) begin
      div_d = '0;
      ph_d = ph_q + 2'h1;
      case (state_q)
        M_START: begin
          if (ph_q == 2'h0) scl_low_d = 1'b0;
          if (ph_q == 2'h1) sda_rel_d = 1'b0;
          if (ph_q == 2'h2) scl_low_d = 1'b1;
          if (ph_q == LAST_PHASE) state_d = M_IDLE;
        end
        M_STOP: begin
          if (ph_q == 2'h0) scl_low_d = 1'b0;
          if (ph_q == 2'h1) sda_rel_d = 1'b1;
          if (ph_q == LAST_PHASE) state_d = M_IDLE;
        end
        default: begin
          if (ph_q == 2'h0) scl_low_d = 1'b0;
          if (ph_q == 2'h1) rx_d = {rx_q[7:0], sda_s};
          if (ph_q == 2'h2) scl_low_d = 1'b1;
          if (ph_q == LAST_PHASE) begin
            if (bit_q == BYTE_BITS) begin
              state_d = M_IDLE;
              sda_rel_d = 1'b1;
              rv_d = 1'b1;
              rd_d = rx_q[8:1];
              ra_d = ~rx_q[0];
            end else begin
              bit_d = bit_q + 4'h1;
              tx_d = {tx_q[7:0], 1'b1};
              sda_rel_d = tx_q[7];
            end
          end
        end
      endcase
    end else begin
      div_d = div_q + DIV_W'(1);
    end
  end

  // Registers; bus idles with both lines released
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= M_IDLE;
      div_q <= '0;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      tx_q <= '1;
      rx_q <= '0;
      scl_low_q <= 1'b0;
      sda_rel_q <= 1'b1;
      rv_q <= 1'b0;
      rd_q <= 8'h00;
      ra_q <= 1'b0;
    end else begin
      state_q <= state_d;
      div_q <= div_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      scl_low_q <= scl_low_d;
      sda_rel_q <= sda_rel_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      ra_q <= ra_d;
    end
  end

  assign bus.scl_m_o = 1'b0;
  assign bus.scl_m_oe_n = ~scl_low_q;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe_n = sda_rel_q;
  assign rsp_valid = rv_q;
  assign rsp_data = rd_q;
  assign rsp_ack = ra_q;
endmodule // tw_master

// ---- dv/tw_checker.sv ----
// Protocol assertions on the two-wire bus between host and memory end.
module tw_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic scl_m_o,
  input wire logic scl_m_oe_n,
  input wire logic sda_m_o,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_o,
  input wire logic sda_s_oe_n,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic start; // Data fell with clock high
  logic stop; // Data rose with clock high
  logic scl_q, scl_d; // Clock level one cycle back
  logic sda_q, sda_d; // Data level one cycle back
  logic idle_q, idle_d; // No transfer open since the last stop
  logic [3:0] cnt_q, cnt_d; // Clock rises since start, saturates

  // Conditions come from registered levels, so no sampled functions here
  always_comb begin
    start = scl_q && scl && sda_q && !sda;
    stop = scl_q && scl && !sda_q && sda;
    scl_d = scl;
    sda_d = sda;
    idle_d = stop ? 1'b1 : (start ? 1'b0 : idle_q);
    cnt_d = start ? 4'h0 : cnt_q + {3'h0, scl && !scl_q && cnt_q != 4'hf};
  end

  // Reset to a released bus, so no false condition at release
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      idle_q <= 1'b1;
      cnt_q <= 4'hf;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
      idle_q <= idle_d;
      cnt_q <= cnt_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Figures assume a quarter bit of 8 clocks on the host end
  // Drivers only pull low, and a driving host end really owns the line
  open_drain_a: assert property (
    !scl_m_o && !sda_m_o && !sda_s_o && (scl == scl_m_oe_n)
    && (sda_m_oe_n || !sda))
    else $error("line driven high");
  slave_stable_a: assert property (
    scl && $past(scl) |-> $stable(sda_s_oe_n))
    else $error("memory end moved data while clock high");
  drive_low_a: assert property (
    $fell(sda_s_oe_n) |-> !scl && !$past(scl, 2))
    else $error("memory end drive started outside clock low");
  release_low_a: assert property ($rose(sda_s_oe_n) |-> !scl)
    else $error("memory end release outside clock low");
  idle_quiet_a: assert property (idle_q |-> sda_s_oe_n)
    else $error("memory end drives while idle");
  addr_silent_a: assert property (
    !idle_q && cnt_q < 4'h8 |-> sda_s_oe_n)
    else $error("memory end drives during address bits");
  start_clock_a: assert property (start |-> ##[1:20] !scl)
    else $error("no clock low after start");
  stop_idle_a: assert property (stop |=> (scl && sda) [*8])
    else $error("bus not idle after stop");
  scl_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
endmodule // tw_checker

// ---- dv/tb_top.sv ----
// Self-checking bench joining host end and memory end over the bus.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tw_pkg::*;
  typedef struct {logic [7:0] dv; logic [7:0] ad; logic [7:0] da;} tw_row_t;
  logic clock = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, cmd_ack = 1'b0;
  logic cmd_ready, rsp_valid, rsp_ack, vcc_low_flag, write_busy, standby;
  logic [7:0] cmd_data = 8'h00, rsp_data, main_addr_prog = 8'hB4;
  logic addr_recalled = 1'b0, write_protect = 1'b0;
  logic vcc_conv_done = 1'b0, vcc_low_meas = 1'b0;
  tw_op_t cmd_op = TW_OP_START;
  int err_count = 0, total_checks = 0;
  tw_row_t rows [4] = '{'{8'hA2, 8'h00, 8'h5A}, '{8'hA2, 8'hFF, 8'h3C},
                       '{8'hA0, 8'hFF, 8'hC3}, '{8'hA2, 8'h07, 8'hA5}};
  tw_if bus_if ();
  tw_master #(.QTR_CYC(8)) tw_master_inst (.clock(clock), .resetn(resetn),
    .bus(bus_if.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  // Long write timer keeps the probe after each write refused
  tw_slave #(.TW_CYC(600)) tw_slave_inst (.clock(clock), .resetn(resetn),
    .bus(bus_if.dev), .main_addr_prog(main_addr_prog),
    .addr_recalled(addr_recalled), .write_protect(write_protect),
    .vcc_conv_done(vcc_conv_done), .vcc_low_meas(vcc_low_meas),
    .vcc_low_flag(vcc_low_flag), .write_busy(write_busy), .standby(standby));
  tw_checker tw_checker_inst (.clock(clock), .resetn(resetn),
    .scl_m_o(bus_if.scl_m_o), .scl_m_oe_n(bus_if.scl_m_oe_n),
    .sda_m_o(bus_if.sda_m_o), .sda_m_oe_n(bus_if.sda_m_oe_n),
    .sda_s_o(bus_if.sda_s_o), .sda_s_oe_n(bus_if.sda_s_oe_n),
    .scl(bus_if.scl), .sda(bus_if.sda));
  always #4 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk8(logic [7:0] g, logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(logic g, logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  // One host command; held until taken, then waits for the end
  task automatic cmd(tw_op_t op, logic [7:0] d, logic a);
    int n;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    cmd_ack = a;
    n = 0;
    // Ready is looked at on the falling edge, where it has settled
    while (cmd_ready !== 1'b1 && n < 9) begin @(negedge clock); n++; end
    if (cmd_ready !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 400) begin @(negedge clock); n++; end
    if (n >= 400) begin
      err_count++;
      report_and_stop();
    end
    // Only byte commands end with a response pulse
    chk1(rsp_valid, op == TW_OP_WRITE || op == TW_OP_READ);
  endtask
  task automatic wb(logic [7:0] d);
    cmd(TW_OP_WRITE, d, 1'b0);
  endtask
  // Start plus address byte, then stop; ack left in rsp_ack
  task automatic probe(logic [7:0] dv, logic e);
    cmd(TW_OP_START, 8'h00, 1'b0);
    wb(dv);
    chk1(rsp_ack, e);
    cmd(TW_OP_STOP, 8'h00, 1'b0);
  endtask
  // Acknowledge polling with a bounded number of tries
  task automatic poll(logic [7:0] dv);
    int k;
    for (k = 0; k < 20; k++) begin
      cmd(TW_OP_START, 8'h00, 1'b0);
      wb(dv);
      if (rsp_ack === 1'b1) break;
    end
    cmd(TW_OP_STOP, 8'h00, 1'b0);
    if (k == 20) begin
      err_count++;
      report_and_stop();
    end
  endtask
  // Dummy write of the pointer, repeated start, read address acked
  task automatic seek_rd(logic [7:0] dv, logic [7:0] ad);
    cmd(TW_OP_START, 8'h00, 1'b0);
    wb(dv);
    wb(ad);
    cmd(TW_OP_START, 8'h00, 1'b0);
    wb(dv | 8'h01);
    chk1(rsp_ack, 1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    chk1(vcc_low_flag, 1'b1);
    chk1(standby, 1'b1);
    // Alarm byte written first, so no unknown bit goes onto the line
    cmd(TW_OP_START, 8'h00, 1'b0);
    wb(8'hA2);
    wb(8'h70);
    wb(8'h00);
    cmd(TW_OP_STOP, 8'h00, 1'b0);
    poll(8'hA2);
    seek_rd(8'hA2, 8'h70);
    cmd(TW_OP_READ, 8'h00, 1'b0);
    cmd(TW_OP_STOP, 8'h00, 1'b0);
    chk8(rsp_data, 8'h10);
    vcc_conv_done = 1'b1;
    @(negedge clock);
    vcc_conv_done = 1'b0;
    chk1(vcc_low_flag, 1'b0);
    seek_rd(8'hA2, 8'h70);
    cmd(TW_OP_READ, 8'h00, 1'b0);
    cmd(TW_OP_STOP, 8'h00, 1'b0);
    chk8(rsp_data, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      cmd(TW_OP_START, 8'h00, 1'b0);
      wb(rows[i].dv);
      chk1(rsp_ack, 1'b1);
      wb(rows[i].ad);
      wb(rows[i].da);
      chk1(rsp_ack, 1'b1);
      cmd(TW_OP_STOP, 8'h00, 1'b0);
      chk1(write_busy, 1'b1);
      probe(rows[i].dv, 1'b0);
      poll(rows[i].dv);
      seek_rd(rows[i].dv, rows[i].ad);
      cmd(TW_OP_READ, 8'h00, 1'b0);
      chk8(rsp_data, rows[i].da);
      cmd(TW_OP_STOP, 8'h00, 1'b0);
      chk1(standby, 1'b1);
      $display("row %0d done", i);
    end
    seek_rd(8'hA2, 8'hFF);
    cmd(TW_OP_READ, 8'h00, 1'b1);
    chk8(rsp_data, 8'h3C);
    cmd(TW_OP_READ, 8'h00, 1'b0);
    chk8(rsp_data, 8'h5A);
    cmd(TW_OP_STOP, 8'h00, 1'b0);
    $display("wrap read done");
    cmd(TW_OP_START, 8'h00, 1'b0);
    wb(8'hA2);
    wb(8'h06);
    for (int i = 0; i < 9; i++) wb(8'h10 + 8'(i));
    cmd(TW_OP_STOP, 8'h00, 1'b0);
    poll(8'hA2);
    cmd(TW_OP_START, 8'h00, 1'b0);
    wb(8'hA3);
    cmd(TW_OP_READ, 8'h00, 1'b0);
    chk8(rsp_data, 8'h11);
    cmd(TW_OP_STOP, 8'h00, 1'b0);
    seek_rd(8'hA2, 8'h00);
    for (int k = 0; k < 8; k++) begin
      cmd(TW_OP_READ, 8'h00, k < 7);
      chk8(rsp_data, (k == 7) ? 8'h11 : 8'h12 + 8'(k));
    end
    cmd(TW_OP_STOP, 8'h00, 1'b0);
    $display("page test done");
    cmd(TW_OP_START, 8'h00, 1'b0);
    wb(8'hA2);
    wb(8'h00);
    wb(8'h77);
    seek_rd(8'hA2, 8'h00);
    chk1(write_busy, 1'b0);
    cmd(TW_OP_READ, 8'h00, 1'b0);
    chk8(rsp_data, 8'h12);
    cmd(TW_OP_STOP, 8'h00, 1'b0);
    $display("unstopped test done");
    write_protect = 1'b1;
    probe(8'hA2, 1'b0);
    write_protect = 1'b0;
    probe(8'hB0, 1'b0);
    chk1(standby, 1'b1);
    probe(8'hB4, 1'b0);
    addr_recalled = 1'b1;
    probe(8'hB4, 1'b1);
    probe(8'hA2, 1'b0);
    $display("address test done");
    // Mid-run reset stands for a fresh power-up, settings not recalled
    resetn = 1'b0;
    addr_recalled = 1'b0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    chk1(vcc_low_flag, 1'b1);
    chk1(standby, 1'b1);
    probe(8'hA2, 1'b1);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule // tb_top
